/* shared/dct_defines.svh */
`ifndef DCT_DEFINES_SVH
`define DCT_DEFINES_SVH

// Register byte addresses
`define DCT_SRC_LOW_ADDR    32'h5000_3610
`define DCT_SRC_HIGH_ADDR   32'h5000_3612
`define DCT_DST_LOW_ADDR    32'h5000_3614
`define DCT_DST_HIGH_ADDR   32'h5000_3616
`define DCT_IRQ_MATCH_ADDR  32'h5000_3618
`define DCT_LEN_ADDR        32'h5000_361a
`define DCT_CTRL_ADDR       32'h5000_361c
`define DCT_INDEX_ADDR      32'h5000_361e
`define DCT_STATUS_ADDR     32'h5000_3620
`define DCT_MASK_ADDR       32'h5000_3622

// Reset value and control write mask
`define DCT_REG_RESET       16'h0000
`define DCT_CTRL_WMASK      16'h3fff

// Control field positions
`define DCT_ON_BIT          0
`define DCT_BW_LSB          1
`define DCT_IRQEN_BIT       3
`define DCT_TRIG_BIT        4
`define DCT_DINC_BIT        5
`define DCT_SINC_BIT        6
`define DCT_CIRC_BIT        7
`define DCT_PRIO_LSB        8
`define DCT_YIELD_BIT       11
`define DCT_FILL_BIT        12
`define DCT_SENSE_BIT       13

// Status bit positions
`define DCT_STS_MATCH       0
`define DCT_STS_DONE        1

`endif

/* shared/dct_pkg.sv */
package dct_pkg;

	typedef enum logic [1:0] {
		IDLE,
		READ,
		WRITE,
		PAUSE
	} dct_state_e;

	typedef struct packed {
		dct_state_e  state;
		logic [15:0] srcLow;
		logic [15:0] srcHigh;
		logic [15:0] dstLow;
		logic [15:0] dstHigh;
		logic [15:0] irqMatch;
		logic [15:0] len;
		logic [15:0] ctrl;
		logic [15:0] idx;
		logic [31:0] fillData;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [15:0] rdata;
		logic        reqPrev;
		logic        reqPend;
		logic        memReq;
		logic        memWe;
		logic [31:0] memAddr;
		logic [1:0]  memSize;
		logic [31:0] memWdata;
		logic        busLock;
		logic        fillLock;
		logic        irq;
	} dct_regs_s;

endpackage

/* rtl/dct_channel.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dct_defines.svh"
module dct_channel
	import dct_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        ce,
	// Register port
	input  wire logic [31:0] regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// Peripheral request
	input  wire logic        dmaReq,
	// Memory bus master
	output logic             memReq,
	output logic             memWe,
	output logic      [31:0] memAddr,
	output logic      [1:0]  memSize,
	output logic      [31:0] memWdata,
	input  wire logic        memGnt,
	input  wire logic [31:0] memRdata,
	// Arbitration
	output logic             busLock,
	output logic             fillLock,
	output logic      [2:0]  prioLevel,
	// Interrupt
	output logic             irq
);

	dct_regs_s st;
	dct_regs_s next_st;

	// Item address: base plus index scaled by bus width when incrementing
	function automatic logic [31:0] itemAddr(input logic [31:0] base, input logic inc,
		input logic [15:0] index, input logic [1:0] bw);
		logic [31:0] step;
		step = {16'h0000, index} << bw;
		itemAddr = inc ? base + step : base;
	endfunction

	// First access of an item: fill mode fetches only for item zero
	function automatic dct_state_e firstState(input logic fill, input logic [15:0] index);
		firstState = (fill && (index != 16'h0000)) ? WRITE : READ;
	endfunction

	// Index-match event of a store; the index compared is the one before it advances
	function automatic logic matchEvent(input logic [15:0] index, input logic [15:0] match, input logic en);
		matchEvent = (index == match) && en;
	endfunction

	logic ctrlWr;
	logic ctrlWrOn;
	logic trig;
	logic reqOk;
	logic yieldEff;
	logic lastItem;
	logic circEff;
	assign ctrlWr   = regWr && (regAddr == `DCT_CTRL_ADDR);
	assign ctrlWrOn = regWdata[`DCT_ON_BIT];
	assign trig     = st.ctrl[`DCT_TRIG_BIT];
	assign reqOk    = st.ctrl[`DCT_SENSE_BIT] ? st.reqPend : dmaReq;
	assign yieldEff = st.ctrl[`DCT_YIELD_BIT] && !trig;
	assign lastItem = (st.idx == st.len);
	// Circular only counts when request paced
	assign circEff  = st.ctrl[`DCT_CIRC_BIT] && trig;

	// Next-state logic for the whole channel
	always_comb begin
		next_st = st;
		next_st.reqPrev = dmaReq;

		case (st.state)
			IDLE: begin
				if (st.ctrl[`DCT_ON_BIT] && (!trig || reqOk)) begin
					next_st.reqPend = 1'b0;
					next_st.state = firstState(st.ctrl[`DCT_FILL_BIT], st.idx);
				end
			end
			READ: begin
				if (memGnt) begin
					next_st.fillData = memRdata;
					next_st.state    = WRITE;
				end
			end
			WRITE: begin
				if (memGnt) begin
					if (matchEvent(st.idx, st.irqMatch, st.ctrl[`DCT_IRQEN_BIT]))
						next_st.status[`DCT_STS_MATCH] = 1'b1;
					if (lastItem) begin
						next_st.idx = 16'h0000;
						next_st.status[`DCT_STS_DONE] = 1'b1;
						if (!circEff)
							next_st.ctrl[`DCT_ON_BIT] = 1'b0;
					end else begin
						next_st.idx = st.idx + 16'h0001;
					end
					// unpaced items follow back to back, no idle bubble
					if (yieldEff)
						next_st.state = PAUSE;
					else if (!lastItem && !trig)
						next_st.state = firstState(st.ctrl[`DCT_FILL_BIT], next_st.idx);
					else
						next_st.state = IDLE;
				end
			end
			PAUSE: begin
				// exactly one free bus cycle, then the next item
				// Going through IDLE here would cost a second free cycle
				if (st.ctrl[`DCT_ON_BIT] && !trig)
					next_st.state = firstState(st.ctrl[`DCT_FILL_BIT], st.idx);
				else
					next_st.state = IDLE;
			end
			default: begin
				next_st.state = IDLE;
			end
		endcase

		// Edge capture; set wins over the clear at start of item
		// rising edge pending
		if (dmaReq && !st.reqPrev)
			next_st.reqPend = 1'b1;

		// Register writes; status clears first so a fresh event survives
		if (regWr) begin
			case (regAddr)
				`DCT_SRC_LOW_ADDR:   next_st.srcLow = regWdata;
				`DCT_SRC_HIGH_ADDR:  next_st.srcHigh = regWdata;
				`DCT_DST_LOW_ADDR:   next_st.dstLow = regWdata;
				`DCT_DST_HIGH_ADDR:  next_st.dstHigh = regWdata;
				`DCT_IRQ_MATCH_ADDR: next_st.irqMatch = regWdata;
				`DCT_LEN_ADDR:       next_st.len = regWdata;
				`DCT_CTRL_ADDR:      next_st.ctrl = regWdata & `DCT_CTRL_WMASK;
				`DCT_STATUS_ADDR:    next_st.status = st.status & ~regWdata[1:0];
				`DCT_MASK_ADDR:      next_st.mask = regWdata[1:0];
				default:             next_st.srcLow = next_st.srcLow;
			endcase
		end
		if (regWr && (regAddr == `DCT_STATUS_ADDR)) begin
			if (st.state == WRITE && memGnt) begin
				if (matchEvent(st.idx, st.irqMatch, st.ctrl[`DCT_IRQEN_BIT]))
					next_st.status[`DCT_STS_MATCH] = 1'b1;
				if (lastItem)
					next_st.status[`DCT_STS_DONE] = 1'b1;
			end
		end

		// Switching off aborts and rewinds the index
		if (ctrlWr && !ctrlWrOn) begin
			next_st.state = IDLE;
			next_st.idx   = 16'h0000;
		end

		// Read data, one cycle after the strobe
		next_st.rdata = 16'h0000;
		if (regRd) begin
			case (regAddr)
				`DCT_SRC_LOW_ADDR:   next_st.rdata = st.srcLow;
				`DCT_SRC_HIGH_ADDR:  next_st.rdata = st.srcHigh;
				`DCT_DST_LOW_ADDR:   next_st.rdata = st.dstLow;
				`DCT_DST_HIGH_ADDR:  next_st.rdata = st.dstHigh;
				`DCT_IRQ_MATCH_ADDR: next_st.rdata = st.irqMatch;
				`DCT_LEN_ADDR:       next_st.rdata = st.len;
				`DCT_CTRL_ADDR:      next_st.rdata = st.ctrl;
				`DCT_INDEX_ADDR:     next_st.rdata = st.idx;
				`DCT_STATUS_ADDR:    next_st.rdata = {14'h0000, st.status};
				`DCT_MASK_ADDR:      next_st.rdata = {14'h0000, st.mask};
				default:             next_st.rdata = 16'h0000;
			endcase
		end

		// Bus outputs follow the next state so they leave flip-flops
		next_st.memReq  = (next_st.state == READ) || (next_st.state == WRITE);
		next_st.memWe   = (next_st.state == WRITE);
		next_st.memSize = next_st.ctrl[`DCT_BW_LSB +: 2];
		if (next_st.state == WRITE)
			next_st.memAddr = itemAddr({next_st.dstHigh, next_st.dstLow},
				next_st.ctrl[`DCT_DINC_BIT], next_st.idx, next_st.memSize);
		else
			next_st.memAddr = itemAddr({next_st.srcHigh, next_st.srcLow},
				next_st.ctrl[`DCT_SINC_BIT], next_st.idx, next_st.memSize);
		// every store repeats the first fetch in fill mode
		next_st.memWdata = next_st.fillData;
		next_st.busLock = next_st.ctrl[`DCT_ON_BIT] && (next_st.state != IDLE) &&
			!(next_st.ctrl[`DCT_YIELD_BIT] && !next_st.ctrl[`DCT_TRIG_BIT]);
		next_st.fillLock = next_st.ctrl[`DCT_ON_BIT] && next_st.ctrl[`DCT_FILL_BIT];
		next_st.irq      = |(next_st.status & next_st.mask);
	end

	// One register for all state; clock enable freezes everything but the synchronous reset
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st <= '0;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Ports come straight from the state register
	assign regRdata  = st.rdata;
	assign memReq    = st.memReq;
	assign memWe     = st.memWe;
	assign memAddr   = st.memAddr;
	assign memSize   = st.memSize;
	assign memWdata  = st.memWdata;
	assign busLock   = st.busLock;
	assign fillLock  = st.fillLock;
	assign prioLevel = st.ctrl[`DCT_PRIO_LSB +: 3];
	assign irq       = st.irq;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_store;
		ce && (st.state == WRITE) && memGnt && !ctrlWr;
	endsequence

	sequence s_matchStore;
		s_store ##0 (st.idx == st.irqMatch) && st.ctrl[`DCT_IRQEN_BIT];
	endsequence

	property p_matchIrq;
		s_matchStore |=> st.status[`DCT_STS_MATCH];
	endproperty
	a_matchIrq: assert property (p_matchIrq) else $error("index match not flagged");

	property p_noIrqDisabled;
		ce && !st.ctrl[`DCT_IRQEN_BIT] && !st.status[`DCT_STS_MATCH] && !ctrlWr
			|=> !st.status[`DCT_STS_MATCH];
	endproperty
	a_noIrqDisabled: assert property (p_noIrqDisabled) else $error("match flagged while disabled");

	property p_lastItem;
		s_store ##0 (st.idx == st.len) && !circEff |=> !st.ctrl[`DCT_ON_BIT] && (st.idx == 16'h0000);
	endproperty
	a_lastItem: assert property (p_lastItem) else $error("transfer did not end after len plus one");

	property p_edgeWait;
		ce && (st.state == IDLE) && trig && st.ctrl[`DCT_SENSE_BIT] && !st.reqPend
			|=> (st.state == IDLE);
	endproperty
	a_edgeWait: assert property (p_edgeWait) else $error("edge mode started without edge");

	property p_fillOneFetch;
		st.memReq && !st.memWe && st.ctrl[`DCT_FILL_BIT] |-> (st.idx == 16'h0000);
	endproperty
	a_fillOneFetch: assert property (p_fillOneFetch) else $error("fill mode fetched twice");

	property p_fillLock;
		st.ctrl[`DCT_FILL_BIT] && (st.state == READ || st.state == WRITE) |-> st.fillLock;
	endproperty
	a_fillLock: assert property (p_fillLock) else $error("fill transfer not locked");

	property p_blockLock;
		(st.state == READ || st.state == WRITE) && !st.ctrl[`DCT_YIELD_BIT] |-> st.busLock;
	endproperty
	a_blockLock: assert property (p_blockLock) else $error("blocking mode left bus open");

	property p_yieldPause;
		s_store ##0 yieldEff |=> (st.state == PAUSE) && !st.busLock && !st.memReq ##1 (!ce || st.state != PAUSE);
	endproperty
	a_yieldPause: assert property (p_yieldPause) else $error("no wait cycle after store");

	property p_indexStep;
		s_store ##0 !lastItem |=> (st.idx == $past(st.idx) + 16'h0001);
	endproperty
	a_indexStep: assert property (p_indexStep) else $error("index did not advance");

	property p_immediate;
		ce && (st.state == IDLE) && st.ctrl[`DCT_ON_BIT] && !trig && !ctrlWr |=> st.memReq;
	endproperty
	a_immediate: assert property (p_immediate) else $error("free-running start delayed");

	property p_circKeep;
		s_store ##0 lastItem && circEff |=> st.ctrl[`DCT_ON_BIT] && (st.idx == 16'h0000);
	endproperty
	a_circKeep: assert property (p_circKeep) else $error("circular mode switched off");

	// A store that is not the last of an unpaced, non-yielding transfer
	sequence s_nextItem;
		s_store ##0 !yieldEff && !trig && !lastItem;
	endsequence

	property p_backToBack;
		s_nextItem |=> st.memReq;
	endproperty
	a_backToBack: assert property (p_backToBack) else $error("bubble between unpaced items");

	property p_fillRepeat;
		s_nextItem ##0 st.ctrl[`DCT_FILL_BIT] |=> st.memReq && st.memWe;
	endproperty
	a_fillRepeat: assert property (p_fillRepeat) else $error("fill mode fetched again");

	property p_copyFetch;
		s_nextItem ##0 !st.ctrl[`DCT_FILL_BIT] |=> st.memReq && !st.memWe;
	endproperty
	a_copyFetch: assert property (p_copyFetch) else $error("copy mode skipped a fetch");

	property p_firstDst;
		st.memReq && st.memWe && (st.idx == 16'h0000) |-> (st.memAddr == {st.dstHigh, st.dstLow});
	endproperty
	a_firstDst: assert property (p_firstDst) else $error("first store not at destination start");

	property p_levelStart;
		ce && (st.state == IDLE) && st.ctrl[`DCT_ON_BIT] && trig && !st.ctrl[`DCT_SENSE_BIT] && dmaReq && !ctrlWr
			|=> st.memReq;
	endproperty
	a_levelStart: assert property (p_levelStart) else $error("level request ignored");

	// Switching off must drop the bus at once, whatever the state
	property p_abort;
		ce && ctrlWr && !ctrlWrOn |=> (st.state == IDLE) && (st.idx == 16'h0000) && !st.memReq;
	endproperty
	a_abort: assert property (p_abort) else $error("switch off did not abort");

	// Read data stand one cycle only, so a stale word is never seen twice
	property p_rdIdle;
		ce && !regRd |=> (st.rdata == 16'h0000);
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read data left standing");

endmodule // dct_channel

/* test/dct_mem_model.sv */
`timescale 1ns/1ps
// Memory and bus slave on the channel's master port
module dct_mem_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// Bench control: hold each grant back two cycles
	input  wire logic        slow,
	// Bus from the channel
	input  wire logic        memReq,
	input  wire logic [31:0] memAddr,
	output logic             memGnt,
	output logic      [31:0] memRdata
);
	// Fetch data is the address folded with a fixed pattern
	localparam logic [31:0] PAT = 32'h5a5a_a5a5;
	logic [1:0]  waitCnt;
	logic [15:0] tick;
	// Wait count of a held request; tick scrambles idle data
	always_ff @(posedge sys_clk) begin
		tick <= srst ? 16'h0 : tick + 16'h1;
		if (srst || (memReq && memGnt))
			waitCnt <= 2'h0;
		else if (memReq)
			waitCnt <= waitCnt + 2'h1;
	end
	// Grant at once, or after two waits when slow
	assign memGnt = memReq && (!slow || waitCnt == 2'h2);
	// Off a grant the data keeps moving, so stale reads show
	assign memRdata = memGnt ? memAddr ^ PAT : {tick, ~tick};
endmodule // dct_mem_model

/* test/dct_channel_tb.sv */
`timescale 1ns/1ps
`include "dct_defines.svh"
module dct_channel_tb;
	localparam logic [31:0] SRC = 32'h2000_0010;
	localparam logic [31:0] DST = 32'h3001_0100;
	localparam logic [31:0] PAT = 32'h5a5a_a5a5;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic        dmaReq = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] regAddr = 32'h0;
	logic [15:0] regWdata = 16'h0;
	logic [15:0] regRdata, rv;
	logic        memReq, memWe, memGnt, busLock, fillLock, irq, lockSeen, fillSeen;
	logic [31:0] memAddr, memWdata, memRdata, sA[$], sD[$];
	logic [1:0]  memSize;
	logic [2:0]  prioLevel;
	int          gC[$];
	int          miscompares = 0, num_checks = 0, cyc = 0, nF = 0;

	dct_channel uut (.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dmaReq(dmaReq), .memReq(memReq), .memWe(memWe),
		.memAddr(memAddr), .memSize(memSize), .memWdata(memWdata), .memGnt(memGnt), .memRdata(memRdata),
		.busLock(busLock), .fillLock(fillLock), .prioLevel(prioLevel), .irq(irq));
	dct_mem_model mem (.sys_clk(sys_clk), .srst(srst), .slow(slow), .memReq(memReq), .memAddr(memAddr),
		.memGnt(memGnt), .memRdata(memRdata));

	// 20 MHz clock
	initial forever #25 sys_clk = ~sys_clk;

	// Log accesses mid-cycle, once every output has settled
	always @(negedge sys_clk) begin
		cyc++;
		if (busLock) lockSeen = 1'b1;
		if (fillLock) fillSeen = 1'b1;
		if (!srst && memReq && memGnt) begin
			gC.push_back(cyc);
			if (memWe) begin
				sA.push_back(memAddr);
				sD.push_back(memWdata);
			end else
				nF++;
		end
	end

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		d = regRdata;
	endtask

	task automatic start(input logic [15:0] c, input logic [15:0] l);
		sA.delete();
		sD.delete();
		gC.delete();
		nF = 0;
		lockSeen = 1'b0;
		fillSeen = 1'b0;
		wr(`DCT_LEN_ADDR, l);
		wr(`DCT_CTRL_ADDR, c);
	endtask

	// Wait for all stores, then judge addresses, data and cleanup
	task automatic finish(input logic [15:0] c, input logic [15:0] l);
		for (int i = 0; i < 400 && sA.size() <= l; i++) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		ck("stores", l + 1, sA.size());
		for (int i = 0; i < sA.size(); i++) begin
			ck("store addr", DST + 4 * i, sA[i]);
			ck("store data", (c[12] ? SRC : SRC + 4 * i) ^ PAT, sD[i]);
		end
		ck("fetches", c[12] ? 1 : l + 1, nF);
		rd(`DCT_CTRL_ADDR, rv);
		ck("ctrl", c & 16'h3ffe, rv);
		rd(`DCT_INDEX_ADDR, rv);
		ck("index", 16'h0, rv);
		ck("prio", c[10:8], prioLevel);
	endtask

	task automatic t_regs;
		logic [31:0] ad [3] = '{`DCT_DST_HIGH_ADDR, `DCT_IRQ_MATCH_ADDR, `DCT_LEN_ADDR};
		for (int i = 0; i < 3; i++) begin
			rd(ad[i], rv);
			ck("reset", 16'h0, rv);
			wr(ad[i], 16'hc35a - i);
			rd(ad[i], rv);
			ck("readback", 16'hc35a - i, rv);
		end
		// Reserved control bits and an unmapped address read zero
		wr(`DCT_CTRL_ADDR, 16'hc000);
		rd(`DCT_CTRL_ADDR, rv);
		ck("ctrl reserved", 16'h0, rv);
		wr(32'h5000_3630, 16'hffff);
		rd(32'h5000_3630, rv);
		ck("unmapped", 16'h0, rv);
		$display("t_regs done");
	endtask

	// Blocking against yielding: lock and spacing of accesses
	task automatic t_modes;
		start(16'h0365, 2);
		finish(16'h0365, 2);
		ck("lock", 1'b1, lockSeen);
		ck("span", 5, gC[gC.size() - 1] - gC[0]);
		start(16'h0865, 2);
		finish(16'h0865, 2);
		ck("lock", 1'b0, lockSeen);
		ck("span", 7, gC[gC.size() - 1] - gC[0]);
		// Fill with destination increment only, unpaced, slow memory
		slow <= 1'b1;
		start(16'h1025, 3);
		finish(16'h1025, 3);
		ck("fill lock", 1'b1, fillSeen);
		slow <= 1'b0;
		$display("t_modes done");
	endtask

	task automatic t_irq;
		wr(`DCT_IRQ_MATCH_ADDR, 16'h2);
		start(16'h006d, 2);
		finish(16'h006d, 2);
		rd(`DCT_STATUS_ADDR, rv);
		ck("status", 16'h3, rv);
		ck("irq masked", 1'b0, irq);
		wr(`DCT_MASK_ADDR, 16'h1);
		repeat (2) @(posedge sys_clk);
		ck("irq", 1'b1, irq);
		wr(`DCT_STATUS_ADDR, 16'h3);
		repeat (2) @(posedge sys_clk);
		ck("irq clear", 1'b0, irq);
		// Interrupt enable off: no match event
		start(16'h0065, 2);
		finish(16'h0065, 2);
		rd(`DCT_STATUS_ADDR, rv);
		ck("status", 16'h2, rv);
		ck("irq", 1'b0, irq);
		$display("t_irq done");
	endtask

	task automatic t_req;
		start(16'h0075, 1);
		repeat (10) @(posedge sys_clk);
		ck("no request", 0, nF);
		dmaReq <= 1'b1;
		finish(16'h0075, 1);
		dmaReq <= 1'b0;
		// A held request gives one item per rising edge only
		start(16'h2075, 2);
		for (int k = 1; k < 3; k++) begin
			dmaReq <= 1'b1;
			repeat (20) @(posedge sys_clk);
			ck("edge items", k, sA.size());
			dmaReq <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
		dmaReq <= 1'b1;
		finish(16'h2075, 2);
		dmaReq <= 1'b0;
		// Circular, level paced: on stays set and the third store wraps to the start
		start(16'h00f5, 1);
		dmaReq <= 1'b1;
		for (int i = 0; i < 400 && sA.size() < 3; i++) @(posedge sys_clk);
		dmaReq <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rd(`DCT_CTRL_ADDR, rv);
		ck("circ on", 16'h00f5, rv);
		ck("circ wrap", DST, sA[2]);
		wr(`DCT_CTRL_ADDR, 16'h0000);
		$display("t_req done");
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs;
		wr(`DCT_SRC_HIGH_ADDR, SRC[31:16]);
		wr(`DCT_SRC_LOW_ADDR, SRC[15:0]);
		wr(`DCT_DST_HIGH_ADDR, DST[31:16]);
		wr(`DCT_DST_LOW_ADDR, DST[15:0]);
		t_modes;
		t_irq;
		t_req;
		complete_run;
	end

	// All tests need a few hundred cycles; this is ample
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		complete_run;
	end
endmodule // dct_channel_tb
